// [pkg/ecc_dma_defines.svh]
// register offsets, field positions, reset values and limits of the scalar and dma register block
//
// Overview of operation
// RULE_01: reads of the scalar word registers are refused and return zero with an error response.
// RULE_02: binary and Koblitz curves of 163, 233, 283, 409 and 571 bits use scalar words 0-5, 0-7, 0-8, 0-12, 0-17.
// RULE_03: prime curves of 192, 224, 256, 384 and 521 bits use scalar words 0-5, 0-6, 0-7, 0-11, 0-16.
// RULE_04: in dma mode the input words are fetched from sram starting at the source address before the operation.
// RULE_05: the two lowest bits of the source address are ignored, so fetches are word aligned.
// RULE_06: software programs the source address before it sets start in dma mode.
// RULE_07: after the operation in dma mode the result words are written to sram from the destination address.
// RULE_08: the two lowest bits of the destination address are ignored, so stores are word aligned.
// RULE_09: software programs the destination address before it sets start in dma mode.
// RULE_10: the first target register names the internal word that takes the first fetched word; writes are blocked while busy.
// RULE_11: the value 0x808 in the first target register selects the first point x coordinate register.
// RULE_12: in dma mode the input word count gives how many source words are fetched.
// RULE_13: at most 144 words are moved; a larger count is flagged as an error and nothing starts.
// RULE_14: source address, destination address and word count are readable and writable.
// RULE_15: fetched words go to consecutive internal words starting at the first target, before the computation starts.
`ifndef ECC_DMA_DEFINES_SVH
`define ECC_DMA_DEFINES_SVH

`define ECC_ADDR_W            12
`define ECC_OFF_SCALAR_FIRST  12'hA00
`define ECC_OFF_SCALAR_LAST   12'hA44
`define ECC_OFF_SRC_ADDR      12'hA48
`define ECC_OFF_DST_ADDR      12'hA4C
`define ECC_OFF_FIRST_TARGET  12'hA50
`define ECC_OFF_WORD_COUNT    12'hA54
`define ECC_OFF_CONTROL       12'hA58
`define ECC_OFF_STATUS        12'hA5C
`define ECC_REG_RESET         32'h00000000
`define ECC_SCALAR_WORDS      18
`define ECC_MAX_WORD_COUNT    32'h00000090
`define ECC_POINT_X1_ADDR     32'h00000808
`define ECC_RAM_AW            8
// control register fields
`define ECC_CTL_START         0
`define ECC_CTL_DMA_EN        1
`define ECC_CTL_BINARY        8
`define ECC_CTL_SIZE_LSB      9
`define ECC_CTL_SIZE_MSB      11
`define ECC_CTL_RCNT_LSB      16
`define ECC_CTL_RCNT_MSB      23
`define ECC_CTL_RBASE_LSB     24
`define ECC_CTL_RBASE_MSB     31
// status register fields
`define ECC_STS_BUSY          0
`define ECC_STS_DONE          1
`define ECC_STS_CNT_ERR       2

// last scalar word index per curve size slot 0..4
`define ECC_K_LAST_B163       5'h05
`define ECC_K_LAST_B233       5'h07
`define ECC_K_LAST_B283       5'h08
`define ECC_K_LAST_B409       5'h0C
`define ECC_K_LAST_B571       5'h11
`define ECC_K_LAST_P192       5'h05
`define ECC_K_LAST_P224       5'h06
`define ECC_K_LAST_P256       5'h07
`define ECC_K_LAST_P384       5'h0B
`define ECC_K_LAST_P521       5'h10

`endif

// [pkg/ecc_dma_pkg.sv]
// types shared by the scalar and dma register block
package ecc_dma_pkg;

	typedef enum logic [2:0]
	{
		S_IDLE        = 3'b000,
		S_FETCH       = 3'b001,
		S_FETCH_WAIT  = 3'b010,
		S_COMPUTE     = 3'b011,
		S_STORE_RD    = 3'b100,
		S_STORE_LATCH = 3'b101,
		S_STORE_WAIT  = 3'b110
	} dma_state_t;

	typedef logic [31:0] word_t;

endpackage

// [src/ecc_operand_ram.sv]
// operand word memory shared by the dma loader and the computation engine
`include "ecc_dma_defines.svh"
module ecc_operand_ram
	import ecc_dma_pkg::*;
(
	// clock
	input  wire logic                      clk,
	// access port
	input  wire logic                      we,
	input  wire logic [`ECC_RAM_AW-1:0]    addr,
	input  wire word_t                     wdata,
	output      word_t                     rdata
);

	word_t mem [0:(1<<`ECC_RAM_AW)-1];

	always_ff @(posedge clk)
	begin
		if (we)
			mem[addr] <= wdata;
	end

	// registered read keeps the memory inferable as block ram
	always_ff @(posedge clk)
	begin
		rdata <= mem[addr];
	end

endmodule

// [src/ecc_axil_port.sv]
// axi4-lite slave handshake: turns bus traffic into one-cycle register strobes
`include "ecc_dma_defines.svh"
module ecc_axil_port
	import ecc_dma_pkg::*;
(
	// clock and reset
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	// axi4-lite
	input  wire logic [`ECC_ADDR_W-1:0]    awaddr,
	input  wire logic                      awvalid,
	output      logic                      awready,
	input  wire word_t                     wdata,
	input  wire logic [3:0]                wstrb,
	input  wire logic                      wvalid,
	output      logic                      wready,
	output      logic [1:0]                bresp,
	output      logic                      bvalid,
	input  wire logic                      bready,
	input  wire logic [`ECC_ADDR_W-1:0]    araddr,
	input  wire logic                      arvalid,
	output      logic                      arready,
	output      word_t                     rdata,
	output      logic [1:0]                rresp,
	output      logic                      rvalid,
	input  wire logic                      rready,
	// register strobes
	output      logic                      wr_en,
	output      logic [`ECC_ADDR_W-1:0]    wr_addr,
	output      word_t                     wr_data,
	output      logic [3:0]                wr_strb,
	input  wire logic                      wr_err,
	output      logic                      rd_en,
	output      logic [`ECC_ADDR_W-1:0]    rd_addr,
	input  wire word_t                     rd_data,
	input  wire logic                      rd_err
);

	logic aw_held;
	logic w_held;

	assign awready = ~aw_held;
	assign wready  = ~w_held;
	assign wr_en   = aw_held & w_held & ~bvalid;
	assign arready = ~rvalid;
	assign rd_en   = arvalid & ~rvalid;
	assign rd_addr = araddr;

	// address and data may arrive in either order; each is held until both are in
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
			wr_strb <= '0;
		end
		else
		begin
			if (awvalid && !aw_held)
			begin
				aw_held <= 1'b1;
				wr_addr <= awaddr;
			end
			else if (wr_en)
				aw_held <= 1'b0;
			if (wvalid && !w_held)
			begin
				w_held  <= 1'b1;
				wr_data <= wdata;
				wr_strb <= wstrb;
			end
			else if (wr_en)
				w_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid <= 1'b0;
			bresp  <= 2'h0;
		end
		else if (wr_en)
		begin
			bvalid <= 1'b1;
			bresp  <= wr_err ? 2'h2 : 2'h0;
		end
		else if (bready)
			bvalid <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata  <= '0;
			rresp  <= 2'h0;
		end
		else if (rd_en)
		begin
			rvalid <= 1'b1;
			rdata  <= rd_data;
			rresp  <= rd_err ? 2'h2 : 2'h0;
		end
		else if (rready)
			rvalid <= 1'b0;
	end

endmodule

// [src/ecc_scalar_dma.sv]
// scalar word registers and dma operand loader / result writer of the point multiplication accelerator
`include "ecc_dma_defines.svh"

module ecc_scalar_dma
	import ecc_dma_pkg::*;
(
	// clock and reset
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	// axi4-lite register bus
	input  wire logic [`ECC_ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output      logic                      s_axi_awready,
	input  wire word_t                     s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output      logic                      s_axi_wready,
	output      logic [1:0]                s_axi_bresp,
	output      logic                      s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [`ECC_ADDR_W-1:0]    s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output      logic                      s_axi_arready,
	output      word_t                     s_axi_rdata,
	output      logic [1:0]                s_axi_rresp,
	output      logic                      s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	// sram dma port
	output      logic                      mem_req,
	output      logic                      mem_we,
	output      word_t                     mem_addr,
	output      word_t                     mem_wdata,
	input  wire word_t                     mem_rdata,
	input  wire logic                      mem_ack,
	// computation engine
	output      logic                      engine_start,
	input  wire logic                      engine_done,
	output      logic [32*`ECC_SCALAR_WORDS-1:0] scalar_multiplier,
	output      logic [4:0]                scalar_last_word,
	input  wire logic                      engine_we,
	input  wire logic [`ECC_RAM_AW-1:0]    engine_addr,
	input  wire word_t                     engine_wdata,
	output      word_t                     engine_rdata
);

	////////////////////////////////////////////////////////////////////////////////
	// register state

	word_t                   source_buffer_pointer;
	word_t                   destination_buffer_pointer;
	word_t                   first_target_register;
	word_t                   input_word_count;
	word_t                   control;
	logic                    done_flag;
	logic                    count_error;
	dma_state_t              state;
	logic [7:0]              word_ctr;
	word_t                   mem_ptr;
	logic                    start_req;
	logic                    busy;

	logic                    wr_en;
	logic [`ECC_ADDR_W-1:0]  wr_addr;
	word_t                   wr_data;
	logic [3:0]              wr_strb;
	logic                    wr_err;
	logic                    rd_en;
	logic [`ECC_ADDR_W-1:0]  rd_addr;
	word_t                   rd_data;
	logic                    rd_err;

	logic                    ram_we;
	logic [`ECC_RAM_AW-1:0]  ram_addr;
	word_t                   ram_wdata;
	word_t                   ram_rdata;

	logic                    wr_scalar;
	logic                    rd_scalar;
	logic [4:0]              wr_scalar_idx;
	logic                    dma_en;
	logic [7:0]              result_count;
	logic [7:0]              result_base;
	logic [`ECC_RAM_AW-1:0]  first_idx;

	assign busy          = (state != S_IDLE);
	assign dma_en        = control[`ECC_CTL_DMA_EN];
	assign result_count  = control[`ECC_CTL_RCNT_MSB:`ECC_CTL_RCNT_LSB];
	assign result_base   = control[`ECC_CTL_RBASE_MSB:`ECC_CTL_RBASE_LSB];
	// internal word index of the target address; 0x808 lands on the first point x word
	assign first_idx     = first_target_register[`ECC_RAM_AW+1:2]; // [RULE_11]
	assign wr_scalar     = (wr_addr >= `ECC_OFF_SCALAR_FIRST) && (wr_addr <= `ECC_OFF_SCALAR_LAST);
	assign rd_scalar     = (rd_addr >= `ECC_OFF_SCALAR_FIRST) && (rd_addr <= `ECC_OFF_SCALAR_LAST);
	assign wr_scalar_idx = wr_addr[6:2];
	assign engine_rdata  = ram_rdata;

	////////////////////////////////////////////////////////////////////////////////
	// bus front end and operand memory

	ecc_axil_port u_axil_port
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (s_axi_awaddr),
		.awvalid (s_axi_awvalid),
		.awready (s_axi_awready),
		.wdata   (s_axi_wdata),
		.wstrb   (s_axi_wstrb),
		.wvalid  (s_axi_wvalid),
		.wready  (s_axi_wready),
		.bresp   (s_axi_bresp),
		.bvalid  (s_axi_bvalid),
		.bready  (s_axi_bready),
		.araddr  (s_axi_araddr),
		.arvalid (s_axi_arvalid),
		.arready (s_axi_arready),
		.rdata   (s_axi_rdata),
		.rresp   (s_axi_rresp),
		.rvalid  (s_axi_rvalid),
		.rready  (s_axi_rready),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.wr_strb (wr_strb),
		.wr_err  (wr_err),
		.rd_en   (rd_en),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.rd_err  (rd_err)
	);

	ecc_operand_ram u_operand_ram
	(
		.clk   (aclk),
		.we    (ram_we),
		.addr  (ram_addr),
		.wdata (ram_wdata),
		.rdata (ram_rdata)
	);

	// the dma owns the memory while moving words; the engine has it otherwise
	always_comb
	begin
		ram_we    = engine_we;
		ram_addr  = engine_addr;
		ram_wdata = engine_wdata;
		if (state == S_FETCH_WAIT)
		begin
			ram_we    = mem_ack;
			ram_addr  = 8'(first_idx + word_ctr); // [RULE_15]
			ram_wdata = mem_rdata;
		end
		else if (state == S_STORE_RD)
		begin
			ram_we    = 1'b0;
			ram_addr  = 8'(result_base + word_ctr);
			ram_wdata = mem_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register writes

	// byte lanes honoured on every writable word
	function automatic word_t merge(input word_t old, input word_t nw, input logic [3:0] strb);
		word_t r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				r[8*b +: 8] = nw[8*b +: 8];
		return r;
	endfunction

	always_comb
	begin
		wr_err = 1'b0;
		unique case (wr_addr)
			`ECC_OFF_SRC_ADDR, `ECC_OFF_DST_ADDR, `ECC_OFF_WORD_COUNT, `ECC_OFF_CONTROL, `ECC_OFF_STATUS:
				wr_err = 1'b0;
			`ECC_OFF_FIRST_TARGET:
				wr_err = busy; // [RULE_10]
			default:
				wr_err = ~wr_scalar;
		endcase
	end

	genvar gi;
	generate
		for (gi = 0; gi < `ECC_SCALAR_WORDS; gi++)
		begin : g_scalar
			// write-only storage: nothing on the read path ever looks at these words
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					scalar_multiplier[32*gi +: 32] <= `ECC_REG_RESET;
				else if (wr_en && wr_scalar && wr_scalar_idx == 5'(gi))
					scalar_multiplier[32*gi +: 32] <= merge(scalar_multiplier[32*gi +: 32], wr_data, wr_strb);
			end
		end
	endgenerate

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			source_buffer_pointer      <= `ECC_REG_RESET;
			destination_buffer_pointer <= `ECC_REG_RESET;
			first_target_register      <= `ECC_REG_RESET;
			input_word_count           <= `ECC_REG_RESET;
			control                    <= `ECC_REG_RESET;
		end
		else if (wr_en)
		begin
			if (wr_addr == `ECC_OFF_SRC_ADDR)
				source_buffer_pointer <= merge(source_buffer_pointer, wr_data, wr_strb); // [RULE_14]
			if (wr_addr == `ECC_OFF_DST_ADDR)
				destination_buffer_pointer <= merge(destination_buffer_pointer, wr_data, wr_strb); // [RULE_14]
			if (wr_addr == `ECC_OFF_FIRST_TARGET && !busy)
				first_target_register <= merge(first_target_register, wr_data, wr_strb); // [RULE_10]
			if (wr_addr == `ECC_OFF_WORD_COUNT)
				input_word_count <= merge(input_word_count, wr_data, wr_strb); // [RULE_14]
			if (wr_addr == `ECC_OFF_CONTROL && !busy)
				control <= merge(control, wr_data, wr_strb) & ~32'h00000001;
		end
	end

	// start is a write-one strobe; ignored while an operation is under way
	assign start_req = wr_en && wr_addr == `ECC_OFF_CONTROL && wr_strb[0] && wr_data[`ECC_CTL_START] && !busy;

	// sticky flags: a set in the same cycle as a clear wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			done_flag   <= 1'b0;
			count_error <= 1'b0;
		end
		else
		begin
			if (wr_en && wr_addr == `ECC_OFF_STATUS && wr_strb[0])
			begin
				if (wr_data[`ECC_STS_DONE])
					done_flag <= 1'b0;
				if (wr_data[`ECC_STS_CNT_ERR])
					count_error <= 1'b0;
			end
			if (state == S_COMPUTE && engine_done && !(dma_en && result_count != 8'h00))
				done_flag <= 1'b1;
			if (state == S_STORE_WAIT && mem_ack && 8'(word_ctr + 8'h01) == result_count)
				done_flag <= 1'b1;
			if (start_req && wr_data[`ECC_CTL_DMA_EN] && input_word_count > `ECC_MAX_WORD_COUNT)
				count_error <= 1'b1; // [RULE_13]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register reads

	always_comb
	begin
		rd_data = '0;
		rd_err  = 1'b0;
		unique case (rd_addr)
			`ECC_OFF_SRC_ADDR:     rd_data = source_buffer_pointer; // [RULE_14]
			`ECC_OFF_DST_ADDR:     rd_data = destination_buffer_pointer; // [RULE_14]
			`ECC_OFF_FIRST_TARGET: rd_data = first_target_register;
			`ECC_OFF_WORD_COUNT:   rd_data = input_word_count; // [RULE_14]
			`ECC_OFF_CONTROL:      rd_data = control;
			`ECC_OFF_STATUS:       rd_data = {29'h0, count_error, done_flag, busy};
			// scalar words hold a private key: reads answer zero with an error
			default:               rd_err  = 1'b1; // [RULE_01]
		endcase
		if (rd_scalar)
			rd_data = '0; // [RULE_01]
	end

	////////////////////////////////////////////////////////////////////////////////
	// curve size to scalar length

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			scalar_last_word <= `ECC_K_LAST_P192;
		else if (control[`ECC_CTL_BINARY])
		begin
			unique case (control[`ECC_CTL_SIZE_MSB:`ECC_CTL_SIZE_LSB])
				3'h0:    scalar_last_word <= `ECC_K_LAST_B163; // [RULE_02]
				3'h1:    scalar_last_word <= `ECC_K_LAST_B233; // [RULE_02]
				3'h2:    scalar_last_word <= `ECC_K_LAST_B283; // [RULE_02]
				3'h3:    scalar_last_word <= `ECC_K_LAST_B409; // [RULE_02]
				3'h4:    scalar_last_word <= `ECC_K_LAST_B571; // [RULE_02]
				default: scalar_last_word <= `ECC_K_LAST_B571;
			endcase
		end
		else
		begin
			unique case (control[`ECC_CTL_SIZE_MSB:`ECC_CTL_SIZE_LSB])
				3'h0:    scalar_last_word <= `ECC_K_LAST_P192; // [RULE_03]
				3'h1:    scalar_last_word <= `ECC_K_LAST_P224; // [RULE_03]
				3'h2:    scalar_last_word <= `ECC_K_LAST_P256; // [RULE_03]
				3'h3:    scalar_last_word <= `ECC_K_LAST_P384; // [RULE_03]
				3'h4:    scalar_last_word <= `ECC_K_LAST_P521; // [RULE_03]
				default: scalar_last_word <= `ECC_K_LAST_P521;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// dma sequencer: fetch, compute, store

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state        <= S_IDLE;
			word_ctr     <= 8'h00;
			mem_ptr      <= `ECC_REG_RESET;
			mem_req      <= 1'b0;
			mem_we       <= 1'b0;
			mem_addr     <= `ECC_REG_RESET;
			mem_wdata    <= `ECC_REG_RESET;
			engine_start <= 1'b0;
		end
		else
		begin
			engine_start <= 1'b0;
			unique case (state)
				S_IDLE:
				begin
					word_ctr <= 8'h00;
					if (start_req && wr_data[`ECC_CTL_DMA_EN])
					begin
						// an oversize count is refused: nothing moves
						if (input_word_count > `ECC_MAX_WORD_COUNT) // [RULE_13]
							state <= S_IDLE;
						else if (input_word_count == `ECC_REG_RESET)
						begin
							state        <= S_COMPUTE;
							engine_start <= 1'b1;
						end
						else
						begin
							mem_ptr <= {source_buffer_pointer[31:2], 2'b00}; // [RULE_05]
							state   <= S_FETCH; // [RULE_04]
						end
					end
					else if (start_req)
					begin
						state        <= S_COMPUTE;
						engine_start <= 1'b1;
					end
				end
				S_FETCH:
				begin
					mem_req  <= 1'b1;
					mem_we   <= 1'b0;
					mem_addr <= mem_ptr; // [RULE_04]
					state    <= S_FETCH_WAIT;
				end
				S_FETCH_WAIT:
				begin
					if (mem_ack)
					begin
						mem_req  <= 1'b0;
						mem_ptr  <= mem_ptr + 32'h00000004;
						word_ctr <= 8'(word_ctr + 8'h01);
						// computation waits until every counted word is in place
						if (32'(word_ctr) + 32'h00000001 == input_word_count) // [RULE_12]
						begin
							state        <= S_COMPUTE; // [RULE_15]
							engine_start <= 1'b1;
						end
						else
							state <= S_FETCH;
					end
				end
				S_COMPUTE:
				begin
					word_ctr <= 8'h00;
					mem_ptr  <= {destination_buffer_pointer[31:2], 2'b00}; // [RULE_08]
					if (engine_done)
						state <= (dma_en && result_count != 8'h00) ? S_STORE_RD : S_IDLE; // [RULE_07]
				end
				S_STORE_RD:
					state <= S_STORE_LATCH;
				S_STORE_LATCH:
				begin
					mem_req   <= 1'b1;
					mem_we    <= 1'b1;
					mem_addr  <= mem_ptr; // [RULE_07]
					mem_wdata <= ram_rdata;
					state     <= S_STORE_WAIT;
				end
				S_STORE_WAIT:
				begin
					if (mem_ack)
					begin
						mem_req  <= 1'b0;
						mem_we   <= 1'b0;
						mem_ptr  <= mem_ptr + 32'h00000004;
						word_ctr <= 8'(word_ctr + 8'h01);
						state    <= (8'(word_ctr + 8'h01) == result_count) ? S_IDLE : S_STORE_RD;
					end
				end
				default:
					state <= S_IDLE;
			endcase
		end
	end

endmodule

// [verif/ecc_sram_model.sv]
// behavioural system sram on the far side of the dma port
module ecc_sram_model
	import ecc_dma_pkg::*;
(
	// clock and pace
	input  wire logic  clk,
	input  wire logic  slow,
	// access port
	input  wire logic  req,
	input  wire logic  we,
	input  wire word_t addr,
	input  wire word_t wdata,
	output      word_t rdata,
	output      logic  ack
);
	word_t      mem [256];
	logic [1:0] waited;

	initial
	begin
		mem = '{default: 32'h0};
		waited = 2'h0;
		ack = 1'b0;
		rdata = 32'h0;
	end

	// read data is good in the ack cycle only; it is scrambled otherwise to catch a late sample
	always @(posedge clk)
	begin
		ack <= 1'b0;
		rdata <= ~rdata;
		if (req && !ack)
		begin
			waited <= waited + 2'h1;
			if (!slow || waited == 2'h3)
			begin
				ack <= 1'b1;
				waited <= 2'h0;
				if (we)
					mem[addr[9:2]] <= wdata;
				else
					rdata <= mem[addr[9:2]];
			end
		end
	end
endmodule

// [verif/ecc_scalar_dma_sva.sv]
// port assertions of the scalar and dma register block
`include "ecc_dma_defines.svh"
module ecc_scalar_dma_sva
	import ecc_dma_pkg::*;
(
	// clock and reset
	input wire logic                   aclk,
	input wire logic                   aresetn,
	// register read channel
	input wire logic [`ECC_ADDR_W-1:0] s_axi_araddr,
	input wire logic                   s_axi_arvalid,
	input wire logic                   s_axi_arready,
	input wire word_t                  s_axi_rdata,
	input wire logic [1:0]             s_axi_rresp,
	input wire logic                   s_axi_rvalid,
	// dma and engine
	input wire logic                   mem_req,
	input wire logic                   mem_we,
	input wire word_t                  mem_addr,
	input wire logic                   mem_ack,
	input wire logic                   engine_start
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire rd_take = s_axi_arvalid && s_axi_arready;

	a_scalar_read_refused:
		assert property (rd_take && s_axi_araddr inside {[12'hA00:12'hA44]}
			|=> s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("scalar read leaked");
	a_pointer_read_ok:
		assert property (rd_take && s_axi_araddr inside {12'hA48, 12'hA4C, 12'hA50, 12'hA54}
			|=> s_axi_rvalid && s_axi_rresp == 2'h0) else $error("pointer read refused");
	a_fetch_aligned:
		assert property (mem_req && !mem_we |-> mem_addr[1:0] == 2'h0) else $error("fetch unaligned");
	a_store_aligned:
		assert property (mem_req && mem_we |-> mem_addr[1:0] == 2'h0) else $error("store unaligned");
	a_request_held:
		assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
			else $error("request changed early");
	a_request_ends:
		assert property (mem_ack |=> !mem_req) else $error("request kept after ack");
	a_fetch_consecutive:
		assert property ((mem_req && !mem_we && mem_ack) ##2 (mem_req && !mem_we)
			|-> mem_addr == $past(mem_addr, 2) + 32'h4) else $error("fetch not consecutive");
	a_start_after_load:
		assert property (engine_start |-> !mem_req ##1 !engine_start) else $error("bad start pulse");

	c_fetch: cover property (mem_ack && !mem_we);
	c_store: cover property (mem_ack && mem_we);
	c_start: cover property (engine_start);
endmodule

bind ecc_scalar_dma ecc_scalar_dma_sva i_ecc_scalar_dma_sva
(
	.aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
	.mem_ack(mem_ack), .engine_start(engine_start)
);

// [verif/test_ecc_scalar_dma_interface.sv]
// self-checking bench of the scalar and dma register block
`include "ecc_dma_defines.svh"
module test_ecc_scalar_dma_interface
	import ecc_dma_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
	logic         arready, rvalid, engine_done, slow, mem_req, mem_we, mem_ack, engine_start;
	logic [11:0]  awaddr, araddr;
	logic [1:0]   bresp, rresp;
	logic [3:0]   wstrb;
	logic [4:0]   scalar_last_word;
	logic [575:0] scalar_multiplier;
	word_t        wdata, rdata, mem_addr, mem_wdata, mem_rdata, engine_rdata;
	int           n_fail, check_count, fetches, starts;
	word_t        vals [4] = '{32'h100, 32'h200, 32'h808, 32'h3};
	logic [4:0]   lasts [10] = '{5'h05, 5'h07, 5'h08, 5'h0C, 5'h11, 5'h05, 5'h06, 5'h07, 5'h0B, 5'h10};

	ecc_scalar_dma i_ecc_scalar_dma
	(
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .engine_start(engine_start),
		.engine_done(engine_done), .scalar_multiplier(scalar_multiplier), .scalar_last_word(scalar_last_word),
		.engine_we(1'b0), .engine_addr(8'h04), .engine_wdata(32'h0), .engine_rdata(engine_rdata)
	);

	ecc_sram_model i_ecc_sram_model
	(
		.clk(aclk), .slow(slow), .req(mem_req), .we(mem_we), .addr(mem_addr),
		.wdata(mem_wdata), .rdata(mem_rdata), .ack(mem_ack)
	);

	initial
	begin
		aclk = 1'b0;
		forever
			#10 aclk = ~aclk;
	end

	always @(posedge aclk)
	begin
		fetches += int'(mem_ack && !mem_we);
		starts += int'(engine_start);
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input word_t seen, input word_t exp);
		check_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input word_t d, output word_t r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		r = {30'h0, bresp};
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, output word_t d, output word_t r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		d = rdata;
		r = {30'h0, rresp};
		rready <= 1'b0;
	endtask

	task automatic close_out();
		$display("checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		word_t d;
		word_t r;
		{aresetn, awvalid, wvalid, bready, arvalid, rready, engine_done, slow} = 8'h01;
		{awaddr, araddr, wdata, wstrb} = {24'h0, 32'h0, 4'hF};
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		for (int k = 0; k < 4; k++)
		begin
			rd(12'hA48 + 12'(4 * k), d, r);
			chk(d, 32'h0);
			wr(12'hA48 + 12'(4 * k), vals[k], r);
			rd(12'hA48 + 12'(4 * k), d, r);
			chk(d, vals[k]);
			chk(r, 32'h0);
		end
		$display("pointer test done");
		for (int k = 0; k < 18; k++)
		begin
			wr(12'hA00 + 12'(4 * k), 32'h5A000000 + k, r);
			chk(scalar_multiplier[32 * k +: 32], 32'h5A000000 + k);
		end
		rd(12'hA44, d, r);
		chk(d, 32'h0);
		chk(r, 32'h2);
		rd(12'hA60, d, r);
		chk(r, 32'h2);
		for (int k = 0; k < 10; k++)
		begin
			wr(12'hA58, {20'h0, 3'(k % 5), 1'(k < 5), 8'h0}, r);
			repeat (2) @(negedge aclk);
			chk({27'h0, scalar_last_word}, {27'h0, lasts[k]});
		end
		$display("scalar test done");
		for (int k = 0; k < 3; k++)
			i_ecc_sram_model.mem[8'h40 + k] = 32'hC0DE0000 + k;
		wr(12'hA48, 32'h103, r);
		wr(12'hA4C, 32'h202, r);
		wr(12'hA58, 32'h02020003, r);
		while (engine_start !== 1'b1)
			@(posedge aclk);
		slow <= 1'b0;
		chk(word_t'(fetches), 32'h3);
		wr(12'hA50, 32'h0, r);
		chk(r, 32'h2);
		engine_done <= 1'b1;
		@(posedge aclk);
		engine_done <= 1'b0;
		do
			rd(12'hA5C, d, r);
		while (d[1] !== 1'b1);
		chk(i_ecc_sram_model.mem[8'h80], 32'hC0DE0000);
		chk(i_ecc_sram_model.mem[8'h81], 32'hC0DE0001);
		chk(i_ecc_sram_model.mem[8'h82], 32'h0);
		chk(engine_rdata, 32'hC0DE0002);
		rd(12'hA50, d, r);
		chk(d, 32'h808);
		$display("dma test done");
		wr(12'hA54, 32'h91, r);
		wr(12'hA58, 32'h02020003, r);
		rd(12'hA5C, d, r);
		chk(d & 32'h4, 32'h4);
		repeat (20) @(posedge aclk);
		chk(word_t'(starts), 32'h1);
		$display("count limit test done");
		close_out();
	end

	initial
	begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		close_out();
	end
endmodule
